// ==== include/shcs_pkg.sv ====
package shcs_pkg;
	// timing
	localparam int CLK_NS = 8;
	localparam int MS_NS = 1000000;
	localparam int TICK_CYCLES = MS_NS / CLK_NS;
	localparam int SW_TIMEOUT_S = 10;
	localparam logic [15:0] SW_TIMEOUT_MS = 16'(SW_TIMEOUT_S * 1000);
	localparam logic [15:0] HOLD_MAX_MS = 16'h270f;
	localparam logic [15:0] PAUSE_MAX_MS = 16'hea60;
	localparam logic [16:0] SLUG_MAX = 17'h186a0;
	// register byte offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_CUT_HOLD = 8'h04;
	localparam logic [7:0] A_CUT_UP = 8'h08;
	localparam logic [7:0] A_PUSH_REACT = 8'h0c;
	localparam logic [7:0] A_PUSH_EXT = 8'h10;
	localparam logic [7:0] A_PAUSE = 8'h14;
	localparam logic [7:0] A_SLUG = 8'h18;
	localparam logic [7:0] A_TAB_LEAD = 8'h1c;
	localparam logic [7:0] A_TAB_TRAIL = 8'h20;
	localparam logic [7:0] A_ORD_SEL = 8'h24;
	localparam logic [7:0] A_ORD_QTY = 8'h28;
	localparam logic [7:0] A_ORD_LEN = 8'h2c;
	localparam logic [7:0] A_ORD_FLAGS = 8'h30;
	localparam logic [7:0] A_STATUS = 8'h34;
	localparam logic [7:0] A_TARGET = 8'h38;
	// control field positions
	localparam int C_RELOAD = 2;
	localparam int C_HALT_EMPTY = 3;
	localparam int C_SPECIAL = 4;
	localparam int C_FLYING = 5;
	localparam int C_FTS = 6;
	localparam int C_START = 8;
	localparam int C_STOP = 9;
	localparam int C_CFG_DONE = 10;
	localparam int C_ERR_CLR = 11;
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// order store
	localparam int NORD = 8;
	localparam logic [2:0] LAST_ORD = 3'h7;

	typedef enum logic [1:0] {POL_GAP, POL_EACH, POL_CONT} shcs_policy_type;
	typedef enum logic [2:0] {ST_HALT, ST_RUN, ST_DOWN, ST_UP, ST_WAIT, ST_PAUSE, ST_NEXT}
		shcs_state_type;

	typedef struct packed {
		logic line_run;
		logic cut;
		logic push;
		logic special;
		logic end_notch;
	} shcs_line_type;

	typedef struct packed {
		shcs_state_type         st;
		shcs_policy_type        pol;
		logic                   reload;
		logic                   halt_empty;
		logic                   flying;
		logic                   fts;
		logic                   cfg;
		logic                   err;
		logic                   chk_done;
		logic                   erase;
		logic                   sw_store;
		logic [15:0]            hold;
		logic [15:0]            up;
		logic [15:0]            react;
		logic [15:0]            ext;
		logic [15:0]            pause;
		logic [16:0]            slug;
		logic [15:0]            lead;
		logic [15:0]            trail;
		logic [2:0]             sel;
		logic [2:0]             cur;
		logic [NORD-1:0][15:0]  qprog;
		logic [NORD-1:0][15:0]  qrem;
		logic [NORD-1:0][23:0]  len;
		logic [NORD-1:0]        endn;
		logic [15:0]            cnt;
		logic [15:0]            pcnt;
		logic [25:0]            tgt;
		shcs_line_type          line;
		logic                   aw_got;
		logic                   w_got;
		logic [7:0]             awaddr;
		logic [31:0]            wdata;
		logic [3:0]             wstrb;
		logic                   bvalid;
		logic [1:0]             bresp;
		logic                   rvalid;
		logic [31:0]            rdata;
		logic [1:0]             rresp;
	} shcs_regs_type;
endpackage : shcs_pkg

// ==== design/shcs_tick.sv ====
`timescale 1ns/1ps
`default_nettype none
module shcs_tick
	import shcs_pkg::*;
#(
	parameter int CYCLES = TICK_CYCLES
) (
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_nrst,
	input  wire logic i_ce,
	// millisecond pulse
	output logic      o_tick
);
	localparam int W = ($clog2(CYCLES) > 0) ? $clog2(CYCLES) : 1;

	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;

	// wrap at one millisecond
	always_comb begin
		o_tick = i_ce && (cnt_reg == W'(CYCLES - 1));
		cnt_next = (cnt_reg == W'(CYCLES - 1)) ? '0 : cnt_reg + 1'b1;
	end

	// counter frozen by clock enable
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			cnt_reg <= '0;
		end else if (i_ce) begin
			cnt_reg <= cnt_next;
		end
	end
endmodule : shcs_tick
`default_nettype wire

// ==== design/shcs_seq.sv ====
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module shcs_seq
	import shcs_pkg::*;
#(
	parameter int TICKS = TICK_CYCLES
) (
	// clock, reset, enable
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_ce,
	// axi4-lite write
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	// axi4-lite read
	input  wire logic [7:0]  i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	// machine side
	input  wire logic        i_cut_req,
	input  wire logic        i_finish_sw,
	output shcs_line_type    o_line,
	// customization switches
	input  wire logic [7:0]  i_sw,
	input  wire logic [7:0]  i_sw_saved,
	output logic             o_erase,
	output logic             o_sw_store,
	output logic             o_config
);
	shcs_regs_type r_reg;
	shcs_regs_type r_next;
	logic          tick;

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// known register offsets
	function automatic logic reg_hit(input logic [7:0] a);
		unique case (a)
			A_CTRL, A_CUT_HOLD, A_CUT_UP, A_PUSH_REACT, A_PUSH_EXT, A_PAUSE, A_SLUG,
			A_TAB_LEAD, A_TAB_TRAIL, A_ORD_SEL, A_ORD_QTY, A_ORD_LEN, A_ORD_FLAGS,
			A_STATUS, A_TARGET: reg_hit = 1'b1;
			default: reg_hit = 1'b0;
		endcase
	endfunction : reg_hit

	// register read image
	function automatic logic [31:0] rd_val(input shcs_regs_type s, input logic [7:0] a);
		rd_val = '0;
		unique case (a)
			A_CTRL: rd_val = {25'h0, s.fts, s.flying, s.line.special, s.halt_empty,
				s.reload, s.pol};
			A_CUT_HOLD: rd_val = {16'h0, s.hold};
			A_CUT_UP: rd_val = {16'h0, s.up};
			A_PUSH_REACT: rd_val = {16'h0, s.react};
			A_PUSH_EXT: rd_val = {16'h0, s.ext};
			A_PAUSE: rd_val = {16'h0, s.pause};
			A_SLUG: rd_val = {15'h0, s.slug};
			A_TAB_LEAD: rd_val = {16'h0, s.lead};
			A_TAB_TRAIL: rd_val = {16'h0, s.trail};
			A_ORD_SEL: rd_val = {29'h0, s.sel};
			A_ORD_QTY: rd_val = {s.qprog[s.sel], s.qrem[s.sel]};
			A_ORD_LEN: rd_val = {8'h0, s.len[s.sel]};
			A_ORD_FLAGS: rd_val = {31'h0, s.endn[s.sel]};
			A_STATUS: rd_val = {13'h0, s.st, 5'h0, s.cur, 3'h0, s.line.push,
				s.line.cut, s.cfg, s.err, s.line.line_run};
			A_TARGET: rd_val = {6'h0, s.tgt};
			default: rd_val = '0;
		endcase
	endfunction : rd_val

	// byte lane merge
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] v,
		input logic [3:0] b);
		merge = o;
		for (int i = 0; i < 4; i++) begin
			if (b[i]) begin
				merge[i*8 +: 8] = v[i*8 +: 8];
			end
		end
	endfunction : merge

	// clamp a millisecond setting, judged on the whole written word
	function automatic logic [15:0] clamp(input logic [31:0] v, input logic [15:0] m);
		clamp = (v > {16'h0, m}) ? m : v[15:0];
	endfunction : clamp

	// order holds both quantity and length
	function automatic logic ready(input shcs_regs_type s, input logic [2:0] i);
		ready = (s.qrem[i] != 16'h0) && (s.len[i] != 24'h0);
	endfunction : ready

	// first ready order after cur, wrapping, cur excluded
	function automatic logic [3:0] find_next(input shcs_regs_type s, input logic [2:0] c);
		logic [2:0] k;
		find_next = 4'h0;
		for (int i = NORD - 1; i >= 1; i--) begin
			k = c + 3'(i);
			if (ready(s, k)) begin
				find_next = {1'b1, k};
			end
		end
	endfunction : find_next

	////////////////////////////////////////////////////////////////////////////
	// millisecond time base

	shcs_tick #(
		.CYCLES (TICKS)
	) u_tick (
		.i_clk  (i_clk),
		.i_nrst (i_nrst),
		.i_ce   (i_ce),
		.o_tick (tick)
	);

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic [31:0] wv;
		logic        start;
		logic        stop;
		logic [15:0] rem;
		logic [3:0]  nx;
		logic        gap_ok;
		wv = '0;
		start = 1'b0;
		stop = 1'b0;
		rem = '0;
		nx = '0;
		gap_ok = 1'b0;
		r_next = r_reg;
		r_next.erase = 1'b0;
		r_next.sw_store = 1'b0;

		// bus answers retire
		if (r_reg.bvalid && i_bready) begin
			r_next.bvalid = 1'b0;
		end
		if (r_reg.rvalid && i_rready) begin
			r_next.rvalid = 1'b0;
		end
		// write address and data taken in either order
		if (i_awvalid && o_awready) begin
			r_next.aw_got = 1'b1;
			r_next.awaddr = i_awaddr;
		end
		if (i_wvalid && o_wready) begin
			r_next.w_got = 1'b1;
			r_next.wdata = i_wdata;
			r_next.wstrb = i_wstrb;
		end
		// read answered one cycle after address
		if (i_arvalid && o_arready) begin
			r_next.rvalid = 1'b1;
			r_next.rdata = rd_val(r_reg, i_araddr);
			r_next.rresp = reg_hit(i_araddr) ? RESP_OKAY : RESP_SLVERR;
		end

		// register write once both halves are in
		if (r_reg.aw_got && r_reg.w_got && !r_reg.bvalid) begin
			wv = merge(rd_val(r_reg, r_reg.awaddr), r_reg.wdata, r_reg.wstrb);
			r_next.aw_got = 1'b0;
			r_next.w_got = 1'b0;
			r_next.bvalid = 1'b1;
			r_next.bresp = reg_hit(r_reg.awaddr) ? RESP_OKAY : RESP_SLVERR;
			unique case (r_reg.awaddr)
				A_CTRL: begin
					r_next.pol = (wv[1:0] == 2'h3) ? POL_GAP : shcs_policy_type'(wv[1:0]);
					r_next.reload = wv[C_RELOAD];
					r_next.halt_empty = wv[C_HALT_EMPTY];
					r_next.line.special = wv[C_SPECIAL];
					r_next.flying = wv[C_FLYING];
					r_next.fts = wv[C_FTS];
					start = wv[C_START];
					stop = wv[C_STOP];
					if (wv[C_CFG_DONE]) begin
						r_next.cfg = 1'b0;
					end
					if (wv[C_ERR_CLR]) begin
						r_next.err = 1'b0;
					end
				end
				A_CUT_HOLD: r_next.hold = clamp(wv, HOLD_MAX_MS);
				A_CUT_UP: r_next.up = clamp(wv, HOLD_MAX_MS);
				A_PUSH_REACT: r_next.react = clamp(wv, HOLD_MAX_MS);
				A_PUSH_EXT: r_next.ext = clamp(wv, HOLD_MAX_MS);
				A_PAUSE: r_next.pause = clamp(wv, PAUSE_MAX_MS);
				A_SLUG: r_next.slug = (wv > {15'h0, SLUG_MAX}) ? SLUG_MAX : wv[16:0];
				A_TAB_LEAD: r_next.lead = wv[15:0];
				A_TAB_TRAIL: r_next.trail = wv[15:0];
				A_ORD_SEL: r_next.sel = wv[2:0];
				A_ORD_QTY: begin
					r_next.qprog[r_reg.sel] = wv[31:16];
					r_next.qrem[r_reg.sel] = wv[31:16];
				end
				A_ORD_LEN: r_next.len[r_reg.sel] = wv[23:0];
				A_ORD_FLAGS: r_next.endn[r_reg.sel] = wv[0];
				default: ;
			endcase
		end

		// switch check on the first enabled cycle after reset
		if (!r_reg.chk_done) begin
			r_next.chk_done = 1'b1;
			if (i_sw != i_sw_saved) begin
				r_next.cfg = 1'b1;
				r_next.erase = 1'b1;
				r_next.sw_store = 1'b1;
				r_next.qprog = '0;
				r_next.qrem = '0;
				r_next.len = '0;
				r_next.endn = '0;
			end
		end

		// die-push interval runs down on the tick
		if (tick && (r_reg.pcnt != 16'h0)) begin
			r_next.pcnt = r_reg.pcnt - 16'h1;
		end

		// cut cycle and order sequencing
		unique case (r_reg.st)
			ST_HALT: begin
				if (start && !r_next.cfg && ready(r_reg, r_reg.cur)) begin
					r_next.st = ST_RUN;
				end
			end
			ST_RUN: begin
				if (stop) begin
					r_next.st = ST_HALT;
				end else if (i_cut_req) begin
					r_next.pcnt = r_reg.react + r_reg.hold + r_reg.ext;
					if (r_reg.hold == 16'h0) begin
						r_next.st = ST_WAIT;
						r_next.cnt = SW_TIMEOUT_MS;
					end else begin
						r_next.st = ST_DOWN;
						r_next.cnt = r_reg.hold;
					end
				end
			end
			ST_DOWN: begin
				if (i_finish_sw || (r_reg.cnt == 16'h0)) begin
					r_next.st = ST_UP;
					r_next.cnt = r_reg.flying ? r_reg.hold : r_reg.up;
				end else if (tick) begin
					r_next.cnt = r_reg.cnt - 16'h1;
				end
			end
			ST_UP: begin
				if (r_reg.cnt == 16'h0) begin
					r_next.st = ST_PAUSE;
					r_next.cnt = r_reg.pause;
				end else if (tick) begin
					r_next.cnt = r_reg.cnt - 16'h1;
				end
			end
			ST_WAIT: begin
				if (i_finish_sw) begin
					r_next.st = ST_PAUSE;
					r_next.cnt = r_reg.pause;
				end else if (r_reg.cnt == 16'h0) begin
					r_next.err = 1'b1;
					r_next.st = ST_HALT;
				end else if (tick) begin
					r_next.cnt = r_reg.cnt - 16'h1;
				end
			end
			ST_PAUSE: begin
				if (r_reg.cnt == 16'h0) begin
					r_next.st = ST_NEXT;
				end else if (tick) begin
					r_next.cnt = r_reg.cnt - 16'h1;
				end
			end
			ST_NEXT: begin
				rem = (r_reg.qrem[r_reg.cur] == 16'h0) ? 16'h0 : r_reg.qrem[r_reg.cur] - 16'h1;
				r_next.qrem[r_reg.cur] = rem;
				r_next.st = ST_RUN;
				if (rem == 16'h0) begin
					if (r_reg.reload) begin
						r_next.qrem[r_reg.cur] = r_reg.qprog[r_reg.cur];
					end
					nx = find_next(r_next, r_reg.cur);
					gap_ok = (r_reg.cur != LAST_ORD) && ready(r_next, r_reg.cur + 3'h1);
					if (!nx[3]) begin
						r_next.st = r_reg.halt_empty ? ST_HALT : ST_RUN;
					end else begin
						r_next.cur = nx[2:0];
						unique case (r_reg.pol)
							POL_GAP: begin
								if (gap_ok) begin
									r_next.cur = r_reg.cur + 3'h1;
								end else begin
									r_next.st = ST_HALT;
								end
							end
							POL_EACH: r_next.st = ST_HALT;
							POL_CONT: r_next.st = ST_RUN;
							default: r_next.st = ST_HALT;
						endcase
					end
				end
			end
			default: r_next.st = ST_HALT;
		endcase

		// line outputs and next cut target
		r_next.line.cut = (r_next.st == ST_DOWN) || (r_next.st == ST_WAIT);
		r_next.line.push = (r_next.pcnt != 16'h0) || r_next.line.cut;
		r_next.line.line_run = (r_next.st == ST_RUN) ||
			(!r_reg.fts && ((r_next.st == ST_DOWN) || (r_next.st == ST_UP) ||
			(r_next.st == ST_WAIT)));
		r_next.line.end_notch = r_next.endn[r_next.cur] && !r_next.line.special;
		r_next.tgt = 26'(r_next.len[r_next.cur]) + 26'(r_next.slug) +
			(r_next.endn[r_next.cur] ? 26'(r_next.lead) + 26'(r_next.trail) : 26'h0);
	end

	////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			r_reg <= '0;
			r_reg.st <= ST_HALT;
			r_reg.pol <= POL_GAP;
		end else if (i_ce) begin
			r_reg <= r_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign o_awready = i_ce && !r_reg.aw_got && !r_reg.bvalid;
	assign o_wready = i_ce && !r_reg.w_got && !r_reg.bvalid;
	assign o_arready = i_ce && !r_reg.rvalid;
	assign o_bvalid = r_reg.bvalid;
	assign o_bresp = r_reg.bresp;
	assign o_rvalid = r_reg.rvalid;
	assign o_rdata = r_reg.rdata;
	assign o_rresp = r_reg.rresp;
	assign o_line = r_reg.line;
	assign o_erase = r_reg.erase;
	assign o_sw_store = r_reg.sw_store;
	assign o_config = r_reg.cfg;
endmodule : shcs_seq
`default_nettype wire

// ==== verification/shcs_seq_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module shcs_seq_props
	import shcs_pkg::*;
#(
	parameter int TICKS = TICK_CYCLES
) (
	// clock and reset
	input  wire logic          i_clk,
	input  wire logic          i_nrst,
	input  wire logic          i_ce,
	// bus read side
	input  wire logic          i_arvalid,
	input  wire logic          o_arready,
	input  wire logic          o_rvalid,
	// machine side
	input  wire logic          i_cut_req,
	input  wire logic          i_finish_sw,
	input  wire shcs_line_type o_line,
	// switches
	input  wire logic [7:0]    i_sw,
	input  wire logic [7:0]    i_sw_saved,
	input  wire logic          o_erase,
	input  wire logic          o_sw_store,
	input  wire logic          o_config
);
	localparam int CUT_MAX = (SW_TIMEOUT_S * 1000 + 2) * TICKS + 4;
	logic [31:0] cut_len_reg;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	////////////////////////////////////////////////////////////////////////
	// cycles the cut solenoid has been on
	always_ff @(posedge i_clk) begin
		if (!i_nrst || !o_line.cut)
			cut_len_reg <= '0;
		else
			cut_len_reg <= cut_len_reg + 32'h1;
	end
	sequence s_cut_begin;
		$rose(o_line.cut);
	endsequence
	sequence s_switch_hit;
		o_line.cut && i_finish_sw;
	endsequence
	sequence s_ar_taken;
		i_arvalid && o_arready && i_ce;
	endsequence
	////////////////////////////////////////////////////////////////////////
	a_cut_from_req: assert property (s_cut_begin |-> $past(i_cut_req))
		else $error("cut started without request");
	a_push_with_cut: assert property (s_cut_begin |-> o_line.push)
		else $error("push not on at cut start");
	a_push_covers_cut: assert property (o_line.cut |-> o_line.push)
		else $error("push dropped during cut");
	a_switch_ends_cut: assert property (s_switch_hit |=> !o_line.cut)
		else $error("cut kept on after finish switch");
	a_cut_bounded: assert property (cut_len_reg <= CUT_MAX)
		else $error("cut on beyond switch timeout");
	a_erase_pair: assert property (o_erase |-> o_sw_store && o_config)
		else $error("erase without store or config");
	a_erase_cause: assert property (o_erase |-> $past(i_sw) != $past(i_sw_saved))
		else $error("erase with unchanged switches");
	a_erase_pulse: assert property (o_erase |=> !o_erase)
		else $error("erase longer than one cycle");
	a_config_halts: assert property (o_config |-> !o_line.line_run)
		else $error("line runs in config mode");
	a_reset_quiet: assert property (disable iff (1'b0)
		!i_nrst |=> o_line == '0 && !o_erase && !o_config)
		else $error("outputs active after reset");
	a_read_answer: assert property (s_ar_taken |=> o_rvalid)
		else $error("read answer late");
endmodule : shcs_seq_props
bind shcs_seq shcs_seq_props #(.TICKS(TICKS)) u_shcs_seq_props (
	.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_arvalid(i_arvalid),
	.o_arready(o_arready), .o_rvalid(o_rvalid), .i_cut_req(i_cut_req),
	.i_finish_sw(i_finish_sw), .o_line(o_line), .i_sw(i_sw), .i_sw_saved(i_sw_saved),
	.o_erase(o_erase), .o_sw_store(o_sw_store), .o_config(o_config));
`default_nettype wire

// ==== verification/shcs_press_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module shcs_press_model (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	// solenoid and switch timing, ffff closes only after 65535 cut cycles
	input  wire logic        i_cut,
	input  wire logic [15:0] i_close_dly,
	input  wire logic [15:0] i_open_dly,
	// cut-finished switch, open reads low
	output logic             o_finish_sw
);
	logic [15:0] cnt_reg;
	logic [15:0] held_reg;
	// switch closes after the stroke, stays closed a while, then opens
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			cnt_reg <= '0;
			held_reg <= '0;
			o_finish_sw <= 1'b0;
		end else if (o_finish_sw) begin
			held_reg <= held_reg + 16'h1;
			if (held_reg >= i_open_dly) begin
				o_finish_sw <= 1'b0;
				held_reg <= '0;
				cnt_reg <= '0;
			end
		end else if (i_cut) begin
			cnt_reg <= cnt_reg + 16'h1;
			if (cnt_reg == i_close_dly - 16'h1)
				o_finish_sw <= 1'b1;
		end else
			cnt_reg <= '0;
	end
endmodule : shcs_press_model
`default_nettype wire

// ==== verification/shcs_seq_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module shcs_seq_bench
	import shcs_pkg::*;
;
	localparam int TK = 4;
	logic          i_clk = 0, i_nrst = 0, i_ce = 1, i_cut_req = 0, i_finish_sw;
	logic          i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
	logic [7:0]    i_awaddr = 0, i_araddr = 0, i_sw = 8'h5a, i_sw_saved = 8'h5a;
	logic [31:0]   i_wdata = 0, o_rdata, rd;
	logic [3:0]    i_wstrb = 0;
	logic          o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic          o_erase, o_sw_store, o_config;
	logic [1:0]    o_bresp, o_rresp, rs;
	shcs_line_type o_line;
	logic [15:0]   close_dly = 16'h0004, open_dly = 16'h0002;
	int            n_mismatch = 0, check_count = 0, cyc = 0, erased = 0;
	int            cc = 0, pc = 0, gc = 0, cut_len = 0, push_len = 0, gap_len = 0;
	logic [7:0]    ca [4] = '{A_CUT_HOLD, A_PUSH_EXT, A_PAUSE, A_SLUG};
	logic [31:0]   cv [4] = '{32'd12000, 32'd10000, 32'd70000, 32'd200000};
	logic [31:0]   ce [4] = '{32'd9999, 32'd9999, 32'd60000, 32'd100000};
	logic [3:0]    pctl [7] = '{4'h0, 4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h0};
	logic [2:0]    pnxt [7] = '{3'h1, 3'h2, 3'h1, 3'h2, 3'h1, 3'h0, 3'h0};
	logic [4:0]    pexp [7] = '{5'h09, 5'h00, 5'h00, 5'h0a, 5'h19, 5'h00, 5'h08};
	////////////////////////////////////////////////////////////////////////
	shcs_seq #(.TICKS(TK)) u_shcs_seq (.i_clk, .i_nrst, .i_ce, .i_awaddr, .i_awvalid,
		.o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid,
		.i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
		.i_rready, .i_cut_req, .i_finish_sw, .o_line, .i_sw, .i_sw_saved, .o_erase,
		.o_sw_store, .o_config);
	shcs_press_model u_shcs_press_model (.i_clk, .i_nrst, .i_cut(o_line.cut),
		.i_close_dly(close_dly), .i_open_dly(open_dly), .o_finish_sw(i_finish_sw));
	always #4 i_clk = ~i_clk;
	////////////////////////////////////////////////////////////////////////
	// saved switches follow the store pulse
	always @(posedge i_clk) begin
		if (o_sw_store === 1'b1) i_sw_saved <= i_sw;
	end
	// pulse lengths, hang limit
	always @(negedge i_clk) begin
		cyc++;
		if (o_erase === 1'b1) erased++;
		if (gc > 0 && o_line.line_run === 1'b1) begin
			gap_len = gc;
			gc = 0;
		end else if (gc > 0) gc++;
		if (o_line.cut === 1'b1) cc++;
		else if (cc > 0) begin
			cut_len = cc;
			cc = 0;
			gc = 1;
		end
		if (o_line.push === 1'b1) pc++;
		else if (pc > 0) begin
			push_len = pc;
			pc = 0;
		end
		if (cyc > 95000) begin
			n_mismatch++;
			final_report();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	function automatic logic [31:0] in_rng(input int v, input int lo, input int hi);
		return (v >= lo && v <= hi) ? 32'h1 : 32'h0;
	endfunction : in_rng
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w, done;
		done = 0;
		i_awaddr <= a;
		i_wdata <= d;
		i_wstrb <= 4'hf;
		i_awvalid <= 1;
		i_wvalid <= 1;
		i_bready <= 1;
		while (!done) begin
			@(negedge i_clk);
			aw = i_awvalid && o_awready;
			w = i_wvalid && o_wready;
			done = o_bvalid && i_bready;
			rs = o_bresp;
			@(posedge i_clk);
			if (aw) i_awvalid <= 0;
			if (w) i_wvalid <= 0;
		end
		i_bready <= 0;
		@(posedge i_clk);
	endtask : wr
	task automatic rdr(input logic [7:0] a);
		logic ar, done;
		done = 0;
		i_araddr <= a;
		i_arvalid <= 1;
		i_rready <= 1;
		while (!done) begin
			@(negedge i_clk);
			ar = i_arvalid && o_arready;
			done = o_rvalid && i_rready;
			rd = o_rdata;
			rs = o_rresp;
			@(posedge i_clk);
			if (ar) i_arvalid <= 0;
		end
		i_rready <= 0;
		@(posedge i_clk);
	endtask : rdr
	task automatic do_reset(input logic [7:0] sw);
		i_nrst <= 0;
		i_sw <= sw;
		repeat (3) @(posedge i_clk);
		i_nrst <= 1;
		erased = 0;
		repeat (3) @(posedge i_clk);
	endtask : do_reset
	task automatic cut_once(input int n);
		i_cut_req <= 1;
		@(posedge i_clk);
		i_cut_req <= 0;
		repeat (n) @(posedge i_clk);
	endtask : cut_once
	task automatic set_ord(input logic [2:0] i);
		wr(A_ORD_SEL, {29'h0, i});
		wr(A_ORD_QTY, 32'h0001_0000);
		wr(A_ORD_LEN, 32'd100);
	endtask : set_ord
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report
	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		do_reset(8'ha5);
		check("erase", erased, 1);
		wr(A_CTRL, 32'h100);
		rdr(A_STATUS);
		check("config", rd[2:0], 3'h4);
		wr(A_CTRL, 32'h400);
		rdr(A_STATUS);
		check("config off", rd[2], 0);
		rdr(A_CTRL);
		check("ctrl", rd, 0);
		rdr(8'h3c);
		check("unmapped rd", rd, 32'h0);
		check("unmapped rresp", {30'h0, rs}, {30'h0, RESP_SLVERR});
		wr(8'h3c, 32'h1);
		check("unmapped wr", rs, RESP_SLVERR);
		for (int i = 0; i < 4; i++) begin
			wr(ca[i], cv[i]);
			rdr(ca[i]);
			check("clamp", rd, ce[i]);
		end
		$display("test registers done");
		wr(A_SLUG, 32'd5);
		wr(A_TAB_LEAD, 32'd3);
		wr(A_TAB_TRAIL, 32'd7);
		set_ord(3'h0);
		wr(A_ORD_FLAGS, 32'h1);
		rdr(A_TARGET);
		check("target notch", rd, 32'd115);
		check("end notch pin", o_line.end_notch, 1);
		wr(A_ORD_FLAGS, 32'h0);
		rdr(A_TARGET);
		check("target blank", rd, 32'd105);
		wr(A_CTRL, 32'h10);
		rdr(A_CTRL);
		check("special", rd[4], 1);
		check("special pin", o_line.special, 1);
		wr(A_ORD_FLAGS, 32'h1);
		check("notch in special", o_line.end_notch, 0);
		$display("test targets done");
		wr(A_CUT_HOLD, 32'd5);
		wr(A_CUT_UP, 32'd3);
		wr(A_PUSH_REACT, 32'd1);
		wr(A_PUSH_EXT, 32'd2);
		wr(A_PAUSE, 32'd2);
		wr(A_ORD_QTY, 32'h0005_0000);
		close_dly <= 16'h0004;
		open_dly <= 16'h0028;
		wr(A_CTRL, 32'h140);
		cut_once(150);
		check("cut by switch", in_rng(cut_len, 4, 7), 1);
		check("push total", in_rng(push_len, 30, 38), 1);
		check("up and pause", in_rng(gap_len, 18, 32), 1);
		close_dly <= 16'hffff;
		wr(A_PUSH_REACT, 32'd0);
		wr(A_PUSH_EXT, 32'd0);
		cut_once(150);
		check("cut by hold", in_rng(cut_len, 18, 27), 1);
		check("push min", in_rng(push_len - cut_len, 0, 8), 1);
		wr(A_CTRL, 32'h160);
		cut_once(150);
		check("flying up", in_rng(gap_len, 26, 36), 1);
		$display("test timed cut done");
		wr(A_CUT_HOLD, 32'd0);
		close_dly <= 16'h0028;
		wr(A_CTRL, 32'h100);
		cut_once(10);
		rdr(A_STATUS);
		check("nonstop wait", rd[3:0] & 4'h9, 4'h9);
		repeat (100) @(posedge i_clk);
		check("cut to switch", in_rng(cut_len, 39, 43), 1);
		close_dly <= 16'hffff;
		wr(A_CTRL, 32'h140);
		cut_once(40100);
		rdr(A_STATUS);
		check("switch timeout", rd[3:0], 4'h2);
		wr(A_CTRL, 32'h800);
		rdr(A_STATUS);
		check("error clear", rd[1], 0);
		$display("test zero hold done");
		close_dly <= 16'h0004;
		open_dly <= 16'h0002;
		for (int i = 0; i < 7; i++) begin
			do_reset(i_sw);
			set_ord(3'h0);
			if (pnxt[i] != 3'h0) set_ord(pnxt[i]);
			wr(A_CTRL, {20'h0, 4'h1, 4'h0, pctl[i]});
			cut_once(60);
			rdr(A_STATUS);
			check("run after order", rd[0], pexp[i][3]);
			if (pexp[i][3]) check("next order", rd[10:8], pexp[i][2:0]);
			wr(A_ORD_SEL, 32'h0);
			rdr(A_ORD_QTY);
			check("remaining", rd[15:0], {15'h0, pexp[i][4]});
		end
		$display("test policies done");
		final_report();
	end
endmodule : shcs_seq_bench
`default_nettype wire
